// >>> design/tap_consts.svh
// Constant definitions for the test access port controller
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH
`define IR_WIDTH 4
`define INS_EXTEST 4'h0
`define INS_INTEST 4'h1
`define INS_SAMPLE 4'h2
`define INS_ABORT 4'h8
`define INS_DPACC 4'hA
`define INS_APACC 4'hB
`define INS_IDCODE 4'hE
`define INS_BYPASS 4'hF
`define IR_CAPTURE 4'h1
`define ID_WIDTH 32
`define BSR_WIDTH 8
`define CORE_DR_WIDTH 35
// Arbitrary identity value, least significant bit set as the identity chain expects
`define ID_DEFAULT 32'h1234_5671
`endif

// >>> design/tap_pkg.sv
// Types shared by the test access port controller
package tap_pkg;
    // Gray-style codes along the usual path
    typedef enum logic [3:0] {
        ST_RESET = 4'h8, ST_IDLE = 4'h0, ST_SEL_DR = 4'h1, ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h7, ST_EXIT1_DR = 4'h6, ST_PAUSE_DR = 4'h2, ST_EXIT2_DR = 4'hA,
        ST_UPD_DR = 4'h4, ST_SEL_IR = 4'h5, ST_CAP_IR = 4'hD, ST_SHIFT_IR = 4'hF,
        ST_EXIT1_IR = 4'hB, ST_PAUSE_IR = 4'h9, ST_EXIT2_IR = 4'hC, ST_UPD_IR = 4'hE
    } tap_state_type;
    // Selected data chain
    typedef enum logic [2:0] {
        SEL_BYPASS = 3'h0, SEL_IDCODE = 3'h1, SEL_BSR = 3'h2, SEL_CORE = 3'h3, SEL_HOLD = 3'h4
    } chain_sel_type;
    // Sampled link pins
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } link_in_type;
endpackage

// >>> design/jtag_tap_controller.sv
// Test access port controller with instruction and data chains, sampled on MCLK
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.svh"
module jtag_tap_controller #(
    parameter logic [`ID_WIDTH-1:0] ID_VALUE = `ID_DEFAULT, // Arbitrary identity value
    parameter int BSR_LEN = `BSR_WIDTH
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic TCK,
    input wire logic TMS_IN,
    input wire logic TDI,
    input wire logic TRST_N,
    input wire logic PIN_ALT_FUNCTION_SELECT_REG,
    input wire logic CORE_TDO,
    input wire logic [BSR_LEN-1:0] PAD_SAMPLE,
    output logic TDO_OUT,
    output logic TDO_OE,
    output logic TMS_OUT,
    output logic TMS_OE,
    output logic CORE_SELECT,
    output logic CORE_CAPTURE,
    output logic CORE_SHIFT,
    output logic CORE_UPDATE,
    output logic [`IR_WIDTH-1:0] INSTRUCTION,
    output logic [BSR_LEN-1:0] BSR_UPDATE,
    output logic DEBUG_FUNCTION,
    output logic [1:0] TAP_RESET_SEEN
);
    import tap_pkg::*;

    link_in_type sync1; // First stage, read only by sync2
    link_in_type sync2; // Second stage
    logic tck_prev; // Previous synced TCK for edge find
    logic tck_rise;
    logic tck_fall;
    logic trst_low;
    tap_state_type state;
    tap_state_type next_state;
    logic [`IR_WIDTH-1:0] ir_shift;
    logic [`ID_WIDTH-1:0] id_shift;
    logic [BSR_LEN-1:0] bsr_shift;
    logic bypass_bit;
    chain_sel_type sel;
    logic tdo_next;

    // Decode shared by the chain steering and the TDO mux
    function automatic chain_sel_type decode(input logic [`IR_WIDTH-1:0] ins);
        case (ins)
            `INS_EXTEST, `INS_INTEST: decode = SEL_HOLD;
            `INS_SAMPLE: decode = SEL_BSR;
            `INS_ABORT, `INS_DPACC, `INS_APACC: decode = SEL_CORE;
            `INS_IDCODE: decode = SEL_IDCODE;
            default: decode = SEL_BYPASS;
        endcase
    endfunction

    // Two-stage synchronisers for all link pins
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            sync1 <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
            sync2 <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
            tck_prev <= 1'b1;
        end else begin
            sync1 <= '{tck: TCK, tms: TMS_IN, tdi: TDI, trst_n: TRST_N};
            sync2 <= sync1;
            tck_prev <= sync2.tck;
        end
    end

    // Edge finds; a stopped TCK gives no edges so no TCK step happens; test reset still acts
    assign tck_rise = sync2.tck & ~tck_prev;
    assign tck_fall = ~sync2.tck & tck_prev;
    assign trst_low = ~sync2.trst_n;
    assign sel = decode(INSTRUCTION);

    // Standard state diagram, TMS sampled at the rise
    always_comb begin
        case (state)
            ST_RESET: next_state = sync2.tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = sync2.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = sync2.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = sync2.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = sync2.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = sync2.tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = sync2.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = sync2.tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = sync2.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = sync2.tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = sync2.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = sync2.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = sync2.tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = sync2.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = sync2.tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = sync2.tms ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    // State register; test reset level overrides clocking
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state <= ST_RESET;
        end else if (trst_low) begin
            state <= ST_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // Instruction chain and its parallel stage
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ir_shift <= `IR_CAPTURE;
            INSTRUCTION <= `INS_IDCODE;
        end else if (trst_low || state == ST_RESET) begin
            INSTRUCTION <= `INS_IDCODE;
        end else if (tck_rise) begin
            case (state)
                ST_CAP_IR: ir_shift <= `IR_CAPTURE;
                ST_SHIFT_IR: ir_shift <= {sync2.tdi, ir_shift[`IR_WIDTH-1:1]};
                ST_UPD_IR: INSTRUCTION <= ir_shift;
                default: begin
                    // Hold
                end
            endcase
        end
    end

    // Data chains: bypass, identity, boundary; frozen for the hold tests
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            bypass_bit <= 1'b0;
            id_shift <= '0;
            bsr_shift <= '0;
            BSR_UPDATE <= '0;
        end else if (tck_rise && sel != SEL_HOLD) begin
            case (state)
                ST_CAP_DR: begin
                    bypass_bit <= 1'b0;
                    if (sel == SEL_IDCODE) id_shift <= ID_VALUE;
                    if (sel == SEL_BSR) bsr_shift <= PAD_SAMPLE;
                end
                ST_SHIFT_DR: begin
                    bypass_bit <= sync2.tdi;
                    if (sel == SEL_IDCODE) id_shift <= {sync2.tdi, id_shift[`ID_WIDTH-1:1]};
                    if (sel == SEL_BSR) bsr_shift <= {sync2.tdi, bsr_shift[BSR_LEN-1:1]};
                end
                ST_UPD_DR: begin
                    if (sel == SEL_BSR) BSR_UPDATE <= bsr_shift;
                end
                default: begin
                    // Hold
                end
            endcase
        end
    end

    // Bit presented by the accessed chain
    always_comb begin
        if (state == ST_SHIFT_IR) begin
            tdo_next = ir_shift[0];
        end else begin
            case (sel)
                SEL_IDCODE: tdo_next = id_shift[0];
                SEL_BSR: tdo_next = bsr_shift[0];
                SEL_CORE: tdo_next = CORE_TDO;
                default: tdo_next = bypass_bit;
            endcase
        end
    end

    // TDO updated on the fall, released outside the shift states
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            TDO_OUT <= 1'b0;
            TDO_OE <= 1'b0;
        end else if (trst_low) begin
            TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            TDO_OUT <= tdo_next;
            TDO_OE <= (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
        end
    end

    // Core select level, and debug strobes one MCLK wide each at a TCK rise
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            CORE_SELECT <= 1'b0;
            CORE_CAPTURE <= 1'b0;
            CORE_SHIFT <= 1'b0;
            CORE_UPDATE <= 1'b0;
        end else begin
            CORE_SELECT <= (sel == SEL_CORE);
            CORE_CAPTURE <= tck_rise && sel == SEL_CORE && state == ST_CAP_DR;
            CORE_SHIFT <= tck_rise && sel == SEL_CORE && state == ST_SHIFT_DR;
            CORE_UPDATE <= tck_rise && sel == SEL_CORE && state == ST_UPD_DR;
        end
    end

    // Pin function: debug after reset; the shared data pin is input only here
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            DEBUG_FUNCTION <= 1'b1;
            TMS_OUT <= 1'b0;
            TMS_OE <= 1'b0;
            TAP_RESET_SEEN <= 2'h0;
        end else begin
            DEBUG_FUNCTION <= PIN_ALT_FUNCTION_SELECT_REG;
            TMS_OUT <= 1'b0; // Serial-wire data return is the core's job
            TMS_OE <= 1'b0;
            TAP_RESET_SEEN <= {TAP_RESET_SEEN[0], state == ST_RESET};
        end
    end
endmodule
`default_nettype wire

// >>> tb/tap_chk.sv
// Port checker for the test access port controller
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.svh"
module tap_chk (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic TCK,
    input wire logic TRST_N,
    input wire logic PIN_ALT_FUNCTION_SELECT_REG,
    input wire logic TDO_OUT,
    input wire logic TDO_OE,
    input wire logic CORE_SELECT,
    input wire logic CORE_SHIFT,
    input wire logic CORE_CAPTURE,
    input wire logic CORE_UPDATE,
    input wire logic [3:0] INSTRUCTION,
    input wire logic DEBUG_FUNCTION,
    input wire logic [1:0] TAP_RESET_SEEN
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    // Link clock still with test reset released
    sequence tck_quiet; (TRST_N && $stable(TCK)) [*8]; endsequence
    // Test reset held past its synchroniser
    sequence trst_held; !TRST_N [*6]; endsequence
    a_idcode_default: assert property (TAP_RESET_SEEN[1] |-> INSTRUCTION == `INS_IDCODE)
        else $error("no idcode in reset");
    a_trst_forces: assert property (trst_held |-> TAP_RESET_SEEN[0])
        else $error("test reset ignored");
    a_tdo_on_fall: assert property ($changed(TDO_OUT) |-> !$past(TCK, 2))
        else $error("tdo moved off the fall");
    a_oe_on_fall: assert property ($changed(TDO_OE) |-> !$past(TCK, 2))
        else $error("tdo enable moved off the fall");
    a_strobe_single: assert property (CORE_SHIFT |=> !CORE_SHIFT)
        else $error("core shift too long");
    a_strobe_core: assert property (CORE_SHIFT |-> CORE_SELECT && $past(TCK))
        else $error("core shift unexpected");
    a_capture_core: assert property (CORE_CAPTURE |-> CORE_SELECT && $past(TCK))
        else $error("core capture unexpected");
    a_update_core: assert property (CORE_UPDATE |-> CORE_SELECT && $past(TCK))
        else $error("core update unexpected");
    a_tck_still: assert property (tck_quiet |-> $stable(INSTRUCTION))
        else $error("instruction moved with tck still");
    a_debug_follow: assert property (PIN_ALT_FUNCTION_SELECT_REG [*3] |-> DEBUG_FUNCTION)
        else $error("debug function lost");
endmodule
bind jtag_tap_controller tap_chk tap_chk_i (.*);
`default_nettype wire

// >>> tb/probe.sv
// Debug probe model driving the link pins
`timescale 1ns/1ps
`default_nettype none
module probe (
    input wire logic MCLK,
    input wire logic TDO,
    output logic TCK = 1'b1,
    output logic TMS = 1'b1,
    output logic TDI = 1'b1,
    output logic TRST_N = 1'b1
);
    logic junk; // Discarded serial bit
    // One link cycle; levels move at the fall so they settle before the rise
    task automatic cyc(input logic m, input logic d, output logic q);
        TCK <= 1'b0;
        TMS <= m;
        TDI <= d;
        repeat (4) @(posedge MCLK);
        TCK <= 1'b1;
        repeat (2) @(posedge MCLK);
        q = TDO; // Mid-high, clear of the update after the fall
        repeat (2) @(posedge MCLK);
    endtask
    // From idle: select, capture, shift n bits LSB first, update, idle
    task automatic access(input logic ir, input int n, input logic [63:0] din,
            output logic [63:0] dout);
        logic b; // One bit seen on TDO
        dout = '0;
        cyc(1'b1, 1'b0, junk);
        if (ir)
            cyc(1'b1, 1'b0, junk);
        repeat (2) cyc(1'b0, 1'b0, junk);
        for (int i = 0; i < n; i++) begin
            cyc(i == n - 1, din[i], b);
            dout[i] = b;
        end
        cyc(1'b1, 1'b0, junk);
        cyc(1'b0, 1'b0, junk);
    endtask
    // Test reset pulse, then time for its synchroniser
    task automatic trst();
        TRST_N <= 1'b0;
        repeat (10) @(posedge MCLK);
        TRST_N <= 1'b1;
        repeat (4) @(posedge MCLK);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the test access port controller
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.svh"
module tb_top;
    localparam logic [31:0] ID = 32'h5EED_0A6B; // Arbitrary identity value
    logic mclk = 1'b0, reset = 1'b1, alt = 1'b1, core_tdo = 1'b0, q;
    logic tck, tms, tdi, trst_n, tdo_out, tdo_oe, core_sel, dbg;
    logic [7:0] pads = 8'hA6, bsr;
    logic [3:0] ins;
    logic [1:0] seen;
    logic [63:0] got;
    int num_errors = 0, comparisons = 0;
    wire logic tdo_pin = tdo_oe ? tdo_out : 1'b1; // Pull-up on a released pin
    probe probe_i (.MCLK(mclk), .TDO(tdo_pin), .TCK(tck), .TMS(tms), .TDI(tdi),
        .TRST_N(trst_n));
    jtag_tap_controller #(.ID_VALUE(ID)) jtag_tap_controller_i (.MCLK(mclk), .RESET(reset),
        .TCK(tck), .TMS_IN(tms), .TDI(tdi), .TRST_N(trst_n), .PIN_ALT_FUNCTION_SELECT_REG(alt),
        .CORE_TDO(core_tdo), .PAD_SAMPLE(pads), .TDO_OUT(tdo_out), .TDO_OE(tdo_oe), .TMS_OUT(),
        .TMS_OE(), .CORE_SELECT(core_sel), .CORE_CAPTURE(), .CORE_SHIFT(), .CORE_UPDATE(),
        .INSTRUCTION(ins), .BSR_UPDATE(bsr), .DEBUG_FUNCTION(dbg), .TAP_RESET_SEEN(seen));
    task automatic check(input string what, input logic [63:0] s, input logic [63:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic ir(input logic [3:0] c);
        probe_i.access(1'b1, 4, 64'(c), got);
        @(posedge mclk); // Core select is registered one clock after the instruction
    endtask
    // Identity, capture values, preload, then frozen chain
    task automatic t_scans();
        probe_i.cyc(1'b0, 1'b0, q);
        check("oe", 64'(tdo_oe), 64'h0);
        probe_i.access(1'b0, 32, 64'h0, got);
        check("id", got, 64'(ID));
        ir(`INS_SAMPLE);
        check("ir cap", got, 64'(`IR_CAPTURE));
        probe_i.access(1'b0, 8, 64'h5C, got);
        check("pads", got, 64'(pads));
        check("bsr", 64'(bsr), 64'h5C);
        ir(`INS_EXTEST);
        probe_i.access(1'b0, 8, 64'h33, got);
        check("frozen", 64'(bsr), 64'h5C);
        $display("test scans done");
    endtask
    // Every code but bypass, an unknown one as bypass, core mux
    task automatic t_codes();
        logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'hA, 4'hB, 4'hE};
        foreach (codes[i]) begin
            ir(codes[i]);
            check("ins", 64'(ins), 64'(codes[i]));
            check("core", 64'(core_sel), 64'(codes[i][3] && codes[i] != 4'hE));
        end
        ir(4'h5);
        probe_i.access(1'b0, 2, 64'h1, got);
        check("bypass", got, 64'h2);
        ir(`INS_DPACC);
        probe_i.access(1'b0, 3, 64'h7, got);
        check("core tdo", got, 64'h0);
        $display("test codes done");
    endtask
    // Four versus five high TMS, test reset, power reset
    task automatic t_resets();
        ir(`INS_SAMPLE);
        probe_i.cyc(1'b1, 1'b0, q);
        repeat (2) probe_i.cyc(1'b0, 1'b0, q);
        repeat (4) probe_i.cyc(1'b1, 1'b0, q);
        check("four high", 64'(ins), 64'(`INS_SAMPLE));
        probe_i.cyc(1'b1, 1'b0, q);
        @(posedge mclk); // Instruction reload lands one clock after the state
        check("five high", 64'(ins), 64'(`INS_IDCODE));
        probe_i.cyc(1'b0, 1'b0, q);
        ir(`INS_SAMPLE);
        probe_i.trst();
        check("trst", 64'(ins), 64'(`INS_IDCODE));
        probe_i.cyc(1'b0, 1'b0, q);
        ir(`INS_SAMPLE);
        alt <= 1'b0;
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        check("por", 64'(ins), 64'(`INS_IDCODE));
        check("por debug", 64'(dbg), 64'h1);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        check("alt off", 64'(dbg), 64'h0);
        alt <= 1'b1;
        repeat (4) @(posedge mclk);
        $display("test resets done");
    endtask
    initial begin
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        t_scans();
        t_codes();
        t_resets();
        give_verdict();
    end
    // Scans need well under a millisecond
    initial begin
        #1000000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
